// >>> logic/bclt_decoder_defines.vh
// Constants for the bit, control, literal and table instruction decoder
// Assumes one fetched 16-bit word per instr_valid_i on the system clock

`ifndef BCLT_DECODER_DEFINES_VH
`define BCLT_DECODER_DEFINES_VH

// ==========================================
// Register offsets and reset values
`define REG_CTRL 4'h0
`define REG_PORT_BASE 4'h4
`define REG_TIMER_ADDR 4'h8
`define REG_STATUS 4'hc
`define PORT_BASE_RST 12'hf00
`define TIMER_ADDR_RST 12'hf10
`define CTRL_PRESC_BIT 0

// ==========================================
// Access bank split
`define ACCESS_SPLIT 8'h60

// ==========================================
// Flag update mask positions
`define FLG_C 0
`define FLG_DIGIT_CARRY 1
`define FLG_Z 2
`define FLG_OVERFLOW 3
`define FLG_N 4

// ==========================================
// Operation codes
`define OP_NOP 6'h00
`define OP_BIT_CLEAR 6'h01
`define OP_BIT_SET 6'h02
`define OP_BIT_TOGGLE 6'h03
`define OP_BIT_TEST_CLEAR 6'h04
`define OP_BIT_TEST_SET 6'h05
`define OP_COND_BRANCH 6'h06
`define OP_REL_JUMP 6'h07
`define OP_REL_CALL 6'h08
`define OP_CALL 6'h09
`define OP_ABS_JUMP 6'h0a
`define OP_WDT_CLEAR 6'h0b
`define OP_STANDBY 6'h0c
`define OP_DEC_ADJUST 6'h0d
`define OP_SOFT_RESET 6'h0e
`define OP_PUSH 6'h0f
`define OP_POP 6'h10
`define OP_INT_RETURN 6'h11
`define OP_SUB_RETURN 6'h12
`define OP_RET_LITERAL 6'h13
`define OP_LIT_ADD 6'h14
`define OP_LIT_SUB 6'h15
`define OP_LIT_AND 6'h16
`define OP_LIT_OR 6'h17
`define OP_LIT_XOR 6'h18
`define OP_LIT_LOAD 6'h19
`define OP_LIT_MUL 6'h1a
`define OP_BANK_LOAD 6'h1b
`define OP_PTR_LOAD 6'h1c
`define OP_TABLE_READ 6'h1d
`define OP_TABLE_WRITE 6'h1e
`define OP_OTHER 6'h1f

`endif

// >>> logic/bit_control_literal_table_decoder.v
// Decoder for the bit, control, literal and table instruction groups
// Assumes flags and addressed file data arrive with each word, same clock
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "bclt_decoder_defines.vh"

module bit_control_literal_table_decoder (
	input wire clk_sys_i,
	input wire srst_i,
	input wire instr_valid_i,
	input wire [15:0] instr_word_i,
	input wire [7:0] file_data_i,
	input wire flag_z_i,
	input wire flag_c_i,
	input wire flag_ovf_i,
	input wire flag_n_i,
	input wire [3:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	output reg op_valid_o,
	output reg [5:0] op_o,
	output reg exec_nop_o,
	output reg [11:0] file_addr_o,
	output reg [2:0] bit_index_o,
	output reg [7:0] literal_o,
	output reg [4:0] flag_upd_o,
	output reg tmo_pwrdn_upd_o,
	output reg skip_o,
	output reg pc_load_o,
	output reg pc_rel_o,
	output reg [10:0] pc_offset_o,
	output reg [19:0] pc_abs_o,
	output reg ret_load_o,
	output reg push_ret_o,
	output reg pop_ret_o,
	output reg fast_ret_o,
	output reg int_enable_set_o,
	output reg work_reg_load_o,
	output reg sw_reset_o,
	output reg ptr_load_o,
	output reg [1:0] ptr_sel_o,
	output reg [11:0] ptr_literal_o,
	output reg [1:0] table_mode_o,
	output reg read_pins_o,
	output reg prescaler_clr_o,
	output reg [3:0] bank_select_o
);

// ==========================================
// States
localparam ST_EXEC = 2'd0;
localparam ST_WORD2 = 2'd1;
localparam ST_DROP = 2'd2;

// ==========================================
// Helpers
function [11:0] map_addr;
	input acc;
	input [7:0] f;
	input [3:0] bank;
	begin
		if (acc)
			map_addr = {bank, f};
		else if (f >= `ACCESS_SPLIT)
			map_addr = {4'hf, f};
		else
			map_addr = {4'h0, f};
	end
endfunction

function cond_true;
	input [2:0] cc;
	input z, c, ovf, n;
	begin
		case (cc)
		3'd0: cond_true = z;
		3'd1: cond_true = ~z;
		3'd2: cond_true = c;
		3'd3: cond_true = ~c;
		3'd4: cond_true = ovf;
		3'd5: cond_true = ~ovf;
		3'd6: cond_true = n;
		default: cond_true = ~n;
		endcase
	end
endfunction

// ==========================================
// State and software registers
reg [1:0] state_reg;
reg [5:0] pend_op_reg;
reg [7:0] pend_lit_reg;
reg pend_s_reg;
reg [1:0] pend_sel_reg;
reg [3:0] bank_reg;
reg presc_assigned_reg;
reg [11:0] port_base_reg;
reg [11:0] timer_addr_reg;

reg [1:0] state_next;
reg [5:0] pend_op_next;
reg [7:0] pend_lit_next;
reg pend_s_next;
reg [1:0] pend_sel_next;
reg [3:0] bank_next;
reg [5:0] op_next;
reg nop_next;
reg [11:0] addr_next;
reg [7:0] lit_next;
reg [4:0] flg_next;
reg tmo_next, skip_next, pcl_next, rel_next;
reg [10:0] off_next;
reg [19:0] abs_next;
reg retl_next, push_next, pop_next, fast_next, inte_next;
reg wl_next, swr_next, ptrl_next;
reg [1:0] psel_next;
reg [11:0] plit_next;
reg [1:0] tmode_next;
reg pins_next, presc_next;

wire [15:0] w = instr_word_i;
wire [11:0] bit_addr = map_addr(w[8], w[7:0], bank_reg);
wire bit_hit = file_data_i[w[11:9]];
wire is_bit_mod = (w[15:12] == 4'h9) | (w[15:12] == 4'h8) |
	(w[15:12] == 4'h7);

// ==========================================
// Decode
always @* begin
	state_next = state_reg;
	pend_op_next = pend_op_reg;
	pend_lit_next = pend_lit_reg;
	pend_s_next = pend_s_reg;
	pend_sel_next = pend_sel_reg;
	bank_next = bank_reg;
	op_next = `OP_NOP;
	nop_next = 1'b0;
	addr_next = 12'h000;
	lit_next = w[7:0];
	flg_next = 5'h00;
	tmo_next = 1'b0;
	skip_next = 1'b0;
	pcl_next = 1'b0;
	rel_next = 1'b0;
	off_next = 11'h000;
	abs_next = 20'h00000;
	retl_next = 1'b0;
	push_next = 1'b0;
	pop_next = 1'b0;
	fast_next = 1'b0;
	inte_next = 1'b0;
	wl_next = 1'b0;
	swr_next = 1'b0;
	ptrl_next = 1'b0;
	psel_next = 2'h0;
	plit_next = 12'h000;
	tmode_next = 2'h0;
	pins_next = 1'b0;
	presc_next = 1'b0;
	if (instr_valid_i) begin
		case (state_reg)
		ST_DROP: begin
			// Dead second cycle or skipped word
			op_next = `OP_NOP;
			nop_next = 1'b1;
			state_next = ST_EXEC;
		end
		ST_WORD2: begin
			// Second word carries operand bits only
			op_next = pend_op_reg;
			state_next = ST_EXEC;
			if (pend_op_reg == `OP_PTR_LOAD) begin
				ptrl_next = 1'b1;
				psel_next = pend_sel_reg;
				plit_next = {pend_lit_reg[3:0], w[7:0]};
			end else begin
				pcl_next = 1'b1;
				abs_next = {w[11:0], pend_lit_reg};
				if (pend_op_reg == `OP_CALL) begin
					push_next = 1'b1;
					fast_next = pend_s_reg;
				end
			end
		end
		default: begin
			case (w[15:12])
			4'h9, 4'h8, 4'h7, 4'hb, 4'ha: begin
				addr_next = bit_addr;
				lit_next = 8'h00;
				if (w[15:12] == 4'h9)
					op_next = `OP_BIT_CLEAR;
				else if (w[15:12] == 4'h8)
					op_next = `OP_BIT_SET;
				else if (w[15:12] == 4'h7)
					op_next = `OP_BIT_TOGGLE;
				else if (w[15:12] == 4'hb)
					op_next = `OP_BIT_TEST_CLEAR;
				else
					op_next = `OP_BIT_TEST_SET;
				// Test ops: skip next word on match
				if ((w[15:12] == 4'hb && !bit_hit) ||
					(w[15:12] == 4'ha && bit_hit)) begin
					skip_next = 1'b1;
					state_next = ST_DROP;
				end
				if (is_bit_mod) begin
					pins_next = (bit_addr[11:4] ==
						port_base_reg[11:4]);
					presc_next = presc_assigned_reg &
						(bit_addr == timer_addr_reg);
				end
			end
			4'he: begin
				if (!w[11]) begin
					op_next = `OP_COND_BRANCH;
					off_next = {{3{w[7]}}, w[7:0]};
					rel_next = 1'b1;
					if (cond_true(w[10:8], flag_z_i, flag_c_i,
						flag_ovf_i, flag_n_i)) begin
						pcl_next = 1'b1;
						state_next = ST_DROP;
					end
				end else if (w[10:9] == 2'b10) begin
					op_next = `OP_CALL;
					pend_op_next = `OP_CALL;
					pend_lit_next = w[7:0];
					pend_s_next = w[8];
					state_next = ST_WORD2;
				end else if (w[10:8] == 3'b111) begin
					op_next = `OP_ABS_JUMP;
					pend_op_next = `OP_ABS_JUMP;
					pend_lit_next = w[7:0];
					state_next = ST_WORD2;
				end else if (w[10:8] == 3'b110 && w[7:6] == 2'b00) begin
					op_next = `OP_PTR_LOAD;
					pend_op_next = `OP_PTR_LOAD;
					pend_lit_next = {4'h0, w[3:0]};
					pend_sel_next = w[5:4];
					state_next = ST_WORD2;
				end else begin
					op_next = `OP_OTHER;
				end
			end
			4'hd: begin
				// Both forms always take the dead cycle
				op_next = w[11] ? `OP_REL_CALL : `OP_REL_JUMP;
				push_next = w[11];
				pcl_next = 1'b1;
				rel_next = 1'b1;
				off_next = w[10:0];
				state_next = ST_DROP;
			end
			4'hf: begin
				op_next = `OP_NOP;
				nop_next = 1'b1;
			end
			4'h0: begin
				case (w[11:8])
				4'hf: begin
					op_next = `OP_LIT_ADD;
					wl_next = 1'b1;
					flg_next = 5'h1f;
				end
				4'h8: begin
					op_next = `OP_LIT_SUB;
					wl_next = 1'b1;
					flg_next = 5'h1f;
				end
				4'hb, 4'h9, 4'ha: begin
					op_next = (w[11:8] == 4'hb) ? `OP_LIT_AND :
						(w[11:8] == 4'h9) ? `OP_LIT_OR : `OP_LIT_XOR;
					wl_next = 1'b1;
					flg_next[`FLG_Z] = 1'b1;
					flg_next[`FLG_N] = 1'b1;
				end
				4'he: begin
					op_next = `OP_LIT_LOAD;
					wl_next = 1'b1;
				end
				4'hd: op_next = `OP_LIT_MUL;
				4'hc: begin
					op_next = `OP_RET_LITERAL;
					wl_next = 1'b1;
					retl_next = 1'b1;
					pop_next = 1'b1;
					state_next = ST_DROP;
				end
				4'h1: begin
					if (w[7:4] == 4'h0) begin
						op_next = `OP_BANK_LOAD;
						bank_next = w[3:0];
					end else begin
						op_next = `OP_OTHER;
					end
				end
				4'h0: begin
					case (w[7:0])
					8'h00: begin
						op_next = `OP_NOP;
						nop_next = 1'b1;
					end
					8'h04: begin
						op_next = `OP_WDT_CLEAR;
						tmo_next = 1'b1;
					end
					8'h03: begin
						op_next = `OP_STANDBY;
						tmo_next = 1'b1;
					end
					8'h07: begin
						op_next = `OP_DEC_ADJUST;
						wl_next = 1'b1;
						flg_next[`FLG_C] = 1'b1;
					end
					8'hff: begin
						op_next = `OP_SOFT_RESET;
						swr_next = 1'b1;
					end
					8'h05: begin
						op_next = `OP_PUSH;
						push_next = 1'b1;
					end
					8'h06: begin
						op_next = `OP_POP;
						pop_next = 1'b1;
					end
					8'h10, 8'h11, 8'h12, 8'h13: begin
						op_next = w[1] ? `OP_SUB_RETURN :
							`OP_INT_RETURN;
						inte_next = ~w[1];
						fast_next = w[0];
						retl_next = 1'b1;
						pop_next = 1'b1;
						state_next = ST_DROP;
					end
					8'h08, 8'h09, 8'h0a, 8'h0b,
					8'h0c, 8'h0d, 8'h0e, 8'h0f: begin
						// Second cycle moves the program memory data
						op_next = w[2] ? `OP_TABLE_WRITE :
							`OP_TABLE_READ;
						tmode_next = w[1:0];
						state_next = ST_DROP;
					end
					default: op_next = `OP_OTHER;
					endcase
				end
				default: op_next = `OP_OTHER;
				endcase
			end
			// Byte-oriented words are passed on undecoded
			default: op_next = `OP_OTHER;
			endcase
		end
		endcase
	end
end

// ==========================================
// Registered outputs
always @(posedge clk_sys_i) begin
	if (srst_i) begin
		state_reg <= ST_EXEC;
		pend_op_reg <= `OP_NOP;
		pend_lit_reg <= 8'h00;
		pend_s_reg <= 1'b0;
		pend_sel_reg <= 2'h0;
		bank_reg <= 4'h0;
		op_valid_o <= 1'b0;
		op_o <= `OP_NOP;
		exec_nop_o <= 1'b0;
		file_addr_o <= 12'h000;
		literal_o <= 8'h00;
		bit_index_o <= 3'h0;
		flag_upd_o <= 5'h00;
		tmo_pwrdn_upd_o <= 1'b0;
		skip_o <= 1'b0;
		pc_load_o <= 1'b0;
		pc_rel_o <= 1'b0;
		pc_offset_o <= 11'h000;
		pc_abs_o <= 20'h00000;
		ret_load_o <= 1'b0;
		push_ret_o <= 1'b0;
		pop_ret_o <= 1'b0;
		fast_ret_o <= 1'b0;
		int_enable_set_o <= 1'b0;
		work_reg_load_o <= 1'b0;
		sw_reset_o <= 1'b0;
		ptr_load_o <= 1'b0;
		ptr_sel_o <= 2'h0;
		ptr_literal_o <= 12'h000;
		table_mode_o <= 2'h0;
		read_pins_o <= 1'b0;
		prescaler_clr_o <= 1'b0;
		bank_select_o <= 4'h0;
	end else begin
		state_reg <= state_next;
		pend_op_reg <= pend_op_next;
		pend_lit_reg <= pend_lit_next;
		pend_s_reg <= pend_s_next;
		pend_sel_reg <= pend_sel_next;
		bank_reg <= bank_next;
		op_valid_o <= instr_valid_i;
		op_o <= op_next;
		exec_nop_o <= nop_next;
		file_addr_o <= addr_next;
		literal_o <= lit_next;
		bit_index_o <= w[11:9];
		flag_upd_o <= flg_next;
		tmo_pwrdn_upd_o <= tmo_next;
		skip_o <= skip_next;
		pc_load_o <= pcl_next;
		pc_rel_o <= rel_next;
		pc_offset_o <= off_next;
		pc_abs_o <= abs_next;
		ret_load_o <= retl_next;
		push_ret_o <= push_next;
		pop_ret_o <= pop_next;
		fast_ret_o <= fast_next;
		int_enable_set_o <= inte_next;
		work_reg_load_o <= wl_next;
		sw_reset_o <= swr_next;
		ptr_load_o <= ptrl_next;
		ptr_sel_o <= psel_next;
		ptr_literal_o <= plit_next;
		table_mode_o <= tmode_next;
		read_pins_o <= pins_next;
		prescaler_clr_o <= presc_next;
		bank_select_o <= bank_next;
	end
end

// ==========================================
// Register port
always @(posedge clk_sys_i) begin
	if (srst_i) begin
		presc_assigned_reg <= 1'b0;
		port_base_reg <= `PORT_BASE_RST;
		timer_addr_reg <= `TIMER_ADDR_RST;
		reg_rdata_o <= 32'h00000000;
	end else begin
		if (reg_wr_i) begin
			if (reg_addr_i == `REG_CTRL)
				presc_assigned_reg <= reg_wdata_i[`CTRL_PRESC_BIT];
			if (reg_addr_i == `REG_PORT_BASE)
				port_base_reg <= reg_wdata_i[11:0];
			if (reg_addr_i == `REG_TIMER_ADDR)
				timer_addr_reg <= reg_wdata_i[11:0];
		end
		// Data valid only the cycle after the strobe
		reg_rdata_o <= 32'h00000000;
		if (reg_rd_i) begin
			case (reg_addr_i)
			`REG_CTRL: reg_rdata_o <= {31'h0, presc_assigned_reg};
			`REG_PORT_BASE: reg_rdata_o <= {20'h0, port_base_reg};
			`REG_TIMER_ADDR: reg_rdata_o <= {20'h0, timer_addr_reg};
			`REG_STATUS: reg_rdata_o <= {20'h0, pend_op_reg,
				state_reg, bank_reg};
			default: reg_rdata_o <= 32'h00000000;
			endcase
		end
	end
end

endmodule // bit_control_literal_table_decoder

// >>> dv/bclt_fetch_model.sv
// Fetch path model: presents words, file data and flags
// Assumes the bench calls its tasks; one word per call
`timescale 1ns/100ps

module bclt_fetch_model (
	input wire clk_sys_i,
	output reg valid_o,
	output reg [15:0] word_o,
	output reg [7:0] fdata_o,
	output reg [3:0] flags_o
);
	initial begin
		valid_o = 1'b0;
		word_o = 16'h0000;
		fdata_o = 8'h00;
		flags_o = 4'h0;
	end

	// ==========
	// Word issue
	task put(input [15:0] w, input [7:0] d, input [3:0] f);
		@(posedge clk_sys_i);
		valid_o <= 1'b1;
		word_o <= w;
		fdata_o <= d;
		flags_o <= f;
	endtask

	// Idle scrambles the bus so a stale word never passes for data
	task idle;
		@(posedge clk_sys_i);
		valid_o <= 1'b0;
		word_o <= ~word_o;
		fdata_o <= ~fdata_o;
	endtask
endmodule // bclt_fetch_model

// >>> dv/bclt_decoder_monitor.sv
// Checker bound to the instruction decoder top
// Assumes one clock domain and a synchronous active high reset
`timescale 1ns/100ps
`include "bclt_decoder_defines.vh"

module bclt_decoder_monitor (
	input wire clk_sys_i,
	input wire srst_i,
	input wire instr_valid_i,
	input wire [15:0] instr_word_i,
	input wire [7:0] file_data_i,
	input wire flag_z_i,
	input wire flag_c_i,
	input wire flag_ovf_i,
	input wire flag_n_i,
	input wire [5:0] op_o,
	input wire exec_nop_o,
	input wire [2:0] bit_index_o,
	input wire [4:0] flag_upd_o,
	input wire tmo_pwrdn_upd_o,
	input wire skip_o,
	input wire pc_load_o,
	input wire pc_rel_o,
	input wire [10:0] pc_offset_o,
	input wire [19:0] pc_abs_o,
	input wire ret_load_o,
	input wire push_ret_o,
	input wire pop_ret_o,
	input wire fast_ret_o,
	input wire int_enable_set_o,
	input wire [3:0] bank_select_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);

	// ==========
	// Branch truth by condition code
	wire [7:0] cond_w;
	assign cond_w = {~flag_n_i, flag_n_i, ~flag_ovf_i, flag_ovf_i,
		~flag_c_i, flag_c_i, ~flag_z_i, flag_z_i};

	// ==========
	// Two-word pair steps
	sequence first_word_s;
		instr_valid_i && (instr_word_i[15:9] == 7'h76 ||
			instr_word_i[15:8] == 8'hef);
	endsequence
	sequence second_word_s;
		instr_valid_i && instr_word_i[15:12] == 4'hf &&
			(op_o == `OP_CALL || op_o == `OP_ABS_JUMP);
	endsequence

	// ==========
	// Assertions
	chk_bit_fields: assert property (
		op_o inside {`OP_BIT_CLEAR, `OP_BIT_SET, `OP_BIT_TOGGLE} |->
		bit_index_o == $past(instr_word_i[11:9]) && flag_upd_o == 5'h00)
		else $error("bit op fields wrong");
	chk_skip_cause: assert property (
		op_o inside {`OP_BIT_TEST_CLEAR, `OP_BIT_TEST_SET} |->
		skip_o == ($past(file_data_i[instr_word_i[11:9]]) ^
		(op_o == `OP_BIT_TEST_CLEAR)))
		else $error("skip decision wrong");
	chk_skip_drop: assert property (
		skip_o && instr_valid_i |=> op_o == `OP_NOP && exec_nop_o)
		else $error("skipped word not dropped");
	chk_branch_taken: assert property (
		op_o == `OP_COND_BRANCH |->
		pc_load_o == $past(cond_w[instr_word_i[10:8]]) &&
		(!pc_load_o || pc_offset_o == {{3{$past(instr_word_i[7])}},
		$past(instr_word_i[7:0])}))
		else $error("conditional branch wrong");
	chk_rel_jump: assert property (
		op_o inside {`OP_REL_JUMP, `OP_REL_CALL} |->
		pc_load_o && pc_rel_o && pc_offset_o == $past(instr_word_i[10:0])
		&& push_ret_o == (op_o == `OP_REL_CALL))
		else $error("relative jump wrong");
	chk_pair_target: assert property (
		first_word_s ##1 second_word_s |=> pc_load_o &&
		pc_abs_o == {$past(instr_word_i[11:0]), $past(instr_word_i[7:0], 2)})
		else $error("two-word target wrong");
	chk_nop_word: assert property (
		instr_valid_i && instr_word_i[15:12] == 4'hf &&
		!(op_o inside {`OP_CALL, `OP_ABS_JUMP, `OP_PTR_LOAD}) |=>
		exec_nop_o && !pc_load_o)
		else $error("lone second word not a nop");
	chk_tmo_pd: assert property (
		op_o inside {`OP_WDT_CLEAR, `OP_STANDBY} |-> tmo_pwrdn_upd_o &&
		$past(instr_word_i) == ((op_o == `OP_WDT_CLEAR) ? 16'h0004 : 16'h0003))
		else $error("timeout flag update wrong");
	chk_return: assert property (
		op_o inside {`OP_INT_RETURN, `OP_SUB_RETURN} |-> ret_load_o &&
		pop_ret_o && fast_ret_o == $past(instr_word_i[0]) &&
		int_enable_set_o == (op_o == `OP_INT_RETURN))
		else $error("return outputs wrong");
	chk_arith_flags: assert property (
		op_o inside {`OP_LIT_ADD, `OP_LIT_SUB} |-> flag_upd_o == 5'h1f)
		else $error("arith flag mask wrong");
	chk_logic_flags: assert property (
		op_o inside {`OP_LIT_AND, `OP_LIT_OR, `OP_LIT_XOR} |->
		flag_upd_o == 5'h14)
		else $error("logic flag mask wrong");
	chk_bank_load: assert property (
		op_o == `OP_BANK_LOAD |-> bank_select_o == $past(instr_word_i[3:0]))
		else $error("bank select not loaded");
endmodule // bclt_decoder_monitor

// >>> dv/test_bit_control_literal_table_decoder.sv
// Bench for the instruction decoder
// Assumes the fetch model drives the word path, bench drives the bus
`timescale 1ns/100ps
`include "bclt_decoder_defines.vh"

module test_bit_control_literal_table_decoder;
	reg clk_sys_i = 1'b0;
	reg srst_i = 1'b1;
	reg [3:0] reg_addr_i = 4'h0;
	reg [31:0] reg_wdata_i = 32'h0;
	reg reg_wr_i = 1'b0;
	reg reg_rd_i = 1'b0;
	wire instr_valid_i, flag_z_i, flag_c_i, flag_ovf_i, flag_n_i;
	wire [15:0] instr_word_i;
	wire [7:0] file_data_i, literal_o;
	wire [31:0] reg_rdata_o;
	wire [5:0] op_o;
	wire [11:0] file_addr_o, ptr_literal_o;
	wire [2:0] bit_index_o;
	wire [4:0] flag_upd_o;
	wire [10:0] pc_offset_o;
	wire [19:0] pc_abs_o;
	wire [1:0] ptr_sel_o, table_mode_o;
	wire [3:0] bank_select_o;
	wire op_valid_o, exec_nop_o, tmo_pwrdn_upd_o, skip_o, pc_load_o;
	wire pc_rel_o;
	wire ret_load_o, push_ret_o, pop_ret_o, fast_ret_o, int_enable_set_o;
	wire work_reg_load_o, sw_reset_o, ptr_load_o, read_pins_o;
	wire prescaler_clr_o;
	// Taken map by condition code for the fixed flag pattern 1010
	wire [7:0] taken_map = 8'h99;
	integer n_mismatch = 0;
	integer n_checks = 0;
	integer i;

	bit_control_literal_table_decoder u_dut (.*);
	bclt_fetch_model u_fm (.clk_sys_i(clk_sys_i), .valid_o(instr_valid_i),
		.word_o(instr_word_i), .fdata_o(file_data_i),
		.flags_o({flag_z_i, flag_c_i, flag_ovf_i, flag_n_i}));

	// ==========
	// Shared tasks
	task check(input [31:0] got, input [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task wr(input [3:0] a, input [31:0] d);
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input [3:0] a, input [31:0] e);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 check(reg_rdata_o, e);
	endtask
	// Outputs seen after nx belong to the word of the previous call
	task nx(input [15:0] w, input [7:0] d);
		u_fm.put(w, d, 4'b1010);
		#1;
	endtask
	// Filler word absorbs any dead cycle of the case under test
	task tcase(input [15:0] w, input [5:0] op, input [4:0] m);
		nx(w, 8'h00);
		nx(16'h0000, 8'h00);
		check({op_o, flag_upd_o, literal_o}, {op, m, w[7:0]});
	endtask

	// ==========
	// Scenarios
	task s_regs;
		rd(4'h4, 32'h0f00);
		rd(4'h8, 32'h0f10);
		wr(4'h4, 32'h0120);
		wr(4'h8, 32'h0126);
		wr(4'h0, 32'h0001);
		rd(4'h4, 32'h0120);
		rd(4'h2, 32'h0000);
		nx(16'h0101, 8'h00);
		nx(16'h8325, 8'h00);
		nx(16'h9126, 8'h00);
		check({read_pins_o, file_addr_o}, {1'b1, 12'h125});
		nx(16'h0000, 8'h00);
		check(prescaler_clr_o, 1'b1);
	endtask
	task s_bits;
		nx(16'h0105, 8'h00);
		nx(16'h8744, 8'h00);
		check(bank_select_o, 4'h5);
		nx(16'h9070, 8'h00);
		check({op_o, bit_index_o, file_addr_o}, {`OP_BIT_SET, 15'h3544});
		nx(16'h7020, 8'h00);
		check({op_o, file_addr_o}, {`OP_BIT_CLEAR, 12'hf70});
		nx(16'h0000, 8'h00);
		check({op_o, file_addr_o}, {`OP_BIT_TOGGLE, 12'h020});
	endtask
	task s_skip;
		nx(16'hb010, 8'hfe);
		nx(16'h0e55, 8'h00);
		check({op_o, skip_o}, {`OP_BIT_TEST_CLEAR, 1'b1});
		nx(16'ha010, 8'hfe);
		check({op_o, exec_nop_o}, {`OP_NOP, 1'b1});
		nx(16'h0e55, 8'h00);
		check({op_o, skip_o}, {`OP_BIT_TEST_SET, 1'b0});
		u_fm.idle;
		#1 check({op_o, work_reg_load_o}, {`OP_LIT_LOAD, 1'b1});
		u_fm.idle;
		#1 check(op_valid_o, 1'b0);
	endtask
	task s_ctrl;
		for (i = 0; i < 8; i = i + 1) begin
			nx(16'he0f0 | (i << 8), 8'h00);
			nx(16'h0000, 8'h00);
			check({op_o, pc_load_o}, {`OP_COND_BRANCH, taken_map[i]});
		end
		nx(16'hd3ff, 8'h00);
		nx(16'hdc01, 8'h00);
		check({op_o, pc_offset_o}, {`OP_REL_JUMP, 11'h3ff});
		nx(16'hdc01, 8'h00);
		check({op_o, exec_nop_o}, {`OP_NOP, 1'b1});
		nx(16'h0000, 8'h00);
		check({op_o, push_ret_o}, {`OP_REL_CALL, 1'b1});
	endtask
	task s_table;
		tcase(16'h0004, `OP_WDT_CLEAR, 5'h00);
		tcase(16'h0003, `OP_STANDBY, 5'h00);
		tcase(16'h0007, `OP_DEC_ADJUST, 5'h01);
		tcase(16'h00ff, `OP_SOFT_RESET, 5'h00);
		check(sw_reset_o, 1'b1);
		tcase(16'h0005, `OP_PUSH, 5'h00);
		check({push_ret_o, pop_ret_o}, 2'b10);
		tcase(16'h0006, `OP_POP, 5'h00);
		check({push_ret_o, pop_ret_o}, 2'b01);
		tcase(16'h0011, `OP_INT_RETURN, 5'h00);
		tcase(16'h0013, `OP_SUB_RETURN, 5'h00);
		tcase(16'h0c33, `OP_RET_LITERAL, 5'h00);
		check({ret_load_o, work_reg_load_o}, 2'b11);
		tcase(16'h0f12, `OP_LIT_ADD, 5'h1f);
		tcase(16'h0812, `OP_LIT_SUB, 5'h1f);
		tcase(16'h0b12, `OP_LIT_AND, 5'h14);
		tcase(16'h0912, `OP_LIT_OR, 5'h14);
		tcase(16'h0a12, `OP_LIT_XOR, 5'h14);
		tcase(16'h0d12, `OP_LIT_MUL, 5'h00);
		for (i = 0; i < 8; i = i + 1) begin
			nx(16'h0008 + i, 8'h00);
			nx(16'h0000, 8'h00);
			check({op_o, table_mode_o}, {(i < 4) ? `OP_TABLE_READ :
				`OP_TABLE_WRITE, i[1:0]});
		end
	endtask
	task s_two;
		nx(16'hec12, 8'h00);
		nx(16'hf345, 8'h00);
		check({op_o, pc_load_o}, {`OP_CALL, 1'b0});
		nx(16'hef78, 8'h00);
		check({pc_load_o, push_ret_o, pc_abs_o}, {2'b11, 20'h34512});
		nx(16'hf9ab, 8'h00);
		nx(16'hee2a, 8'h00);
		check({op_o, pc_abs_o}, {`OP_ABS_JUMP, 20'h9ab78});
		nx(16'hf0bc, 8'h00);
		nx(16'hf123, 8'h00);
		check({ptr_load_o, ptr_sel_o, ptr_literal_o}, 15'h6abc);
		nx(16'hb010, 8'h00);
		check({op_o, exec_nop_o}, {`OP_NOP, 1'b1});
		nx(16'hec12, 8'h00);
		nx(16'hf345, 8'h00);
		nx(16'h0000, 8'h00);
		check({pc_load_o, exec_nop_o}, 2'b01);
	endtask

	// ==========
	// Clock, watchdog and main sequence
	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		#40000;
		n_mismatch = n_mismatch + 1;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		s_regs;
		s_bits;
		s_skip;
		s_ctrl;
		s_table;
		s_two;
		give_verdict;
	end
endmodule // test_bit_control_literal_table_decoder

bind bit_control_literal_table_decoder bclt_decoder_monitor u_mon (.*);
